/* File: dv/nos_front_model.sv */
// front end model: phase phasors from a wanted sum, residual channel magnitudes
module nos_front_model (
	input wire logic signed [15:0] sum_re, // wanted sum, real
	input wire logic signed [15:0] sum_im, // wanted sum, imaginary
	input wire logic [15:0] mag_a, // channel a magnitude
	input wire logic [15:0] mag_b, // channel b magnitude
	output logic signed [15:0] ul1_re, // phase 1 real
	output logic signed [15:0] ul1_im, // phase 1 imaginary
	output logic signed [15:0] ul2_re, // phase 2 real
	output logic signed [15:0] ul2_im, // phase 2 imaginary
	output logic signed [15:0] ul3_re, // phase 3 real
	output logic signed [15:0] ul3_im, // phase 3 imaginary
	output logic [15:0] residual_channel_a, // channel a
	output logic [15:0] residual_channel_b // channel b
);
	// large opposing phasors cancel; summing magnitudes instead would show
	assign ul1_re = sum_re + 16'sh0BB8;
	assign ul2_re = -16'sh0BB8;
	assign ul3_re = 16'sh0000;
	assign ul1_im = 16'sh0000;
	assign ul2_im = sum_im - 16'sh03E8;
	assign ul3_im = 16'sh03E8;
	assign residual_channel_a = mag_a;
	assign residual_channel_b = mag_b;
endmodule

/* File: dv/nos_stage_monitor.sv */
// checker of the stage's bus handshake and status outputs
module nos_stage_monitor (
	input wire logic sys_clk, // clock
	input wire logic rstn, // reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pready, // apb ready
	input wire logic [31:0] prdata, // read data
	input wire logic pslverr, // bus error
	input wire logic start_o, // start
	input wire logic trip_o, // trip
	input wire logic blocked_o, // blocked
	input wire logic no_residual_flag, // no residual
	input wire logic chan_a_res_mode, // chan a residual mode
	input wire logic [1:0] meas_now_o // channel in use
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// a bus access takes exactly one wait state
	sequence s_wait; psel && penable && !pready; endsequence
	sequence s_done; psel && penable && pready; endsequence
	property p_one_wait; s_wait |=> s_done; endproperty
	a_one_wait: assert property (p_one_wait) else $error("ready not after one wait");
	property p_no_early; pready |-> s_done and $past(psel && penable); endproperty
	a_no_early: assert property (p_no_early) else $error("ready outside access");
	property p_rd_idle; !pready |-> prdata == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside ready");
	property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
	a_err: assert property (p_err) else $error("bad error response");
	property p_blk; blocked_o |-> !start_o && !trip_o; endproperty
	a_blk: assert property (p_blk) else $error("blocked with start or trip");
	property p_nores; no_residual_flag |-> meas_now_o == 2'h0; endproperty
	a_nores: assert property (p_nores) else $error("flag with a channel");
	property p_chan_a; meas_now_o == 2'h2 |-> chan_a_res_mode; endproperty
	a_chan_a: assert property (p_chan_a) else $error("chan a not residual");
	// channel in use holds for eight cycles after each change
	property p_upd; $changed(meas_now_o) |=> $stable(meas_now_o) [*8]; endproperty
	a_upd: assert property (p_upd) else $error("channel flickers");
endmodule
bind nos_stage nos_stage_monitor nos_stage_monitor_i (.sys_clk, .rstn, .psel, .penable,
	.pready, .prdata, .pslverr, .start_o, .trip_o, .blocked_o, .no_residual_flag,
	.chan_a_res_mode, .meas_now_o);

/* File: dv/nos_stage_tb.sv */
// testbench of the neutral overvoltage stage
module nos_stage_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PC = 300; // short program cycle keeps the run brief
	logic sys_clk = 1'h0, rstn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, start_o, trip_o, blocked_o, test_o, nores;
	logic block_in = 1'h0, ln = 1'h1, cam = 1'h1, cbm = 1'h1, sgr = 1'h0;
	logic [2:0] sgs = 3'h0;
	logic signed [15:0] sre = 16'sh0, sim = 16'sh0, u1r, u1i, u2r, u2i, u3r, u3i;
	logic [15:0] ma = 16'h0, mb = 16'h0, ra, rb;
	logic [15:0] mh [4] = '{16'h07D0, 16'h07D1, 16'h0794, 16'h0793};
	logic [1:0] meas;
	int bad_count = 0, cmp_count = 0;
	always #5 sys_clk = ~sys_clk;
	nos_stage #(.PROG_CYCLE_CLKS(PC)) nos_stage_i (.sys_clk, .rstn, .paddr, .psel, .penable,
		.pwrite, .pwdata, .pready, .prdata, .pslverr, .ul1_re(u1r), .ul1_im(u1i),
		.ul2_re(u2r), .ul2_im(u2i), .ul3_re(u3r), .ul3_im(u3i), .ln_present(ln),
		.residual_channel_a(ra), .residual_channel_b(rb), .chan_a_res_mode(cam),
		.chan_b_res_mode(cbm), .block_in, .sg_logic_req(sgr), .sg_logic_sel(sgs), .start_o,
		.trip_o, .blocked_o, .test_o, .no_residual_flag(nores), .meas_now_o(meas));
	nos_front_model nos_front_model_i (.sum_re(sre), .sum_im(sim), .mag_a(ma), .mag_b(mb),
		.ul1_re(u1r), .ul1_im(u1i), .ul2_re(u2r), .ul2_im(u2i), .ul3_re(u3r), .ul3_im(u3i),
		.residual_channel_a(ra), .residual_channel_b(rb));
	task automatic final_report();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	// one apb transfer, entered just after a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'h1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (n >= 20) begin
			bad_count++;
			final_report();
		end
		@(posedge sys_clk);
	endtask
	task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		chk(n, rd, e);
	endtask
	task automatic tk(input int n);
		repeat (n * PC) @(posedge sys_clk);
	endtask
	initial begin
		repeat (6) @(posedge sys_clk);
		rstn <= 1'h1;
		@(posedge sys_clk);
		rdc("ctrl", 12'h000, 32'h0);
		rdc("thr", 12'h040, 32'h7D0);
		rdc("hole", 12'h030, 32'h0);
		chk("slverr", {31'h0, err}, 32'h1);
		// unset select falls back to the phasor sum: |(5400,7200)|/3 = 3000
		sre <= 16'sh1518;
		sim <= 16'sh1C20;
		tk(3);
		chk("meas", {30'h0, meas}, 32'h1);
		chk("start", {31'h0, start_o}, 32'h1);
		chk("trip", {31'h0, trip_o}, 32'h0);
		rdc("ratio", 12'h010, 32'h96);
		rdc("expt", 12'h008, 32'h8);
		rdc("prim", 12'h014, 32'h4E20);
		rdc("remt", 12'h00C, 32'h6);
		tk(8);
		chk("trip", {31'h0, trip_o}, 32'h1);
		sre <= 16'sh0;
		sim <= 16'sh0;
		apb(1'h1, 12'h000, 32'h200);
		tk(16);
		// pick-up edge and 97 percent release on channel a
		for (int i = 0; i < 4; i++) begin
			ma <= mh[i];
			tk(2);
			apb(1'h0, 12'h004, 32'h0);
			chk("pickup", {31'h0, rd[4]}, {28'h0, 4'h6 >> i & 4'h1});
		end
		chk("meas", {30'h0, meas}, 32'h2);
		apb(1'h1, 12'h050, 32'h76C);
		apb(1'h1, 12'h018, 32'h1);
		tk(2);
		rdc("pick g1", 12'h004, 32'h32);
		rdc("ctrl", 12'h000, 32'h200);
		sgr <= 1'h1;
		@(posedge sys_clk);
		sgr <= 1'h0;
		tk(2);
		rdc("sgsel", 12'h018, 32'h0);
		rdc("pick g0", 12'h004, 32'h22);
		// block raised long before any delay could end
		block_in <= 1'h1;
		ma <= 16'h0BB8;
		apb(1'h1, 12'h044, 32'h80000000);
		tk(3);
		chk("blk", {29'h0, blocked_o, trip_o, start_o}, 32'h4);
		rdc("idmt", 12'h008, 32'h14);
		block_in <= 1'h0;
		ma <= 16'h0;
		cbm <= 1'h0;
		tk(3);
		apb(1'h1, 12'h000, 32'h300);
		rdc("ctrl b", 12'h000, 32'h200);
		for (int m = 0; m < 6; m++) begin
			apb(1'h1, 12'h000, 32'h200 | m);
			tk(1);
			rdc("mode", 12'h000, 32'h200 | (m < 5 ? m : 4));
			chk("test", {31'h0, test_o}, {31'h0, m == 2 || m == 3});
		end
		for (int f = 1; f < 4; f++) begin
			apb(1'h1, 12'h000, 32'h1200 | f << 4);
			repeat (3) @(posedge sys_clk);
			chk("force", {31'h0, f == 1 ? start_o : f == 2 ? trip_o : blocked_o}, 32'h1);
		end
		apb(1'h1, 12'h000, 32'h0);
		ln <= 1'h0;
		tk(3);
		chk("nores", {30'h0, nores, meas[0]}, 32'h2);
		final_report();
	end
endmodule

/* File: src/nos_defines.svh */
// register offsets, field positions, reset values and timing counts of the stage
`ifndef NOS_DEFINES_SVH
`define NOS_DEFINES_SVH

// ****************************************
// timing
// ****************************************
`define NOS_CLK_MHZ 100
`define NOS_STEP_MS 5
`define NOS_PROG_CYCLE_CLKS (`NOS_STEP_MS * 1000 * `NOS_CLK_MHZ)
`define NOS_TIME_MAX_S 1800
`define NOS_TIME_MAX (`NOS_TIME_MAX_S * 1000 / `NOS_STEP_MS)

// ****************************************
// arithmetic scales
// ****************************************
`define NOS_HYST_PCT 97
`define NOS_PCT_FULL 100
`define NOS_IDMT_SCALE (10 * `NOS_PCT_FULL / `NOS_STEP_MS)
`define NOS_PRIM_DIV 1000
`define NOS_RATIO_MAX 125000
`define NOS_DIV_STEPS 40
`define NOS_SQRT_BITS 18

// ****************************************
// register offsets
// ****************************************
`define NOS_CTRL 12'h000
`define NOS_STAT 12'h004
`define NOS_EXPT 12'h008
`define NOS_REMT 12'h00C
`define NOS_RATIO 12'h010
`define NOS_PRIM 12'h014
`define NOS_SGSEL 12'h018
`define NOS_UN_CALC 12'h01C
`define NOS_UN_A 12'h020
`define NOS_UN_B 12'h024
`define NOS_SG_BASE 12'h040

// ****************************************
// field positions
// ****************************************
`define NOS_CTRL_MODE 0
`define NOS_CTRL_FORCE 4
`define NOS_CTRL_INSEL 8
`define NOS_CTRL_FEN 12
`define NOS_STAT_MEAS 0
`define NOS_STAT_PICKUP 4
`define NOS_STAT_START 5
`define NOS_STAT_TRIP 6
`define NOS_STAT_BLOCKED 7
`define NOS_STAT_BEHAV 8
`define NOS_STAT_NORES 12
`define NOS_SGF_THR 2'h0
`define NOS_SGF_DT 2'h1
`define NOS_SGF_K 2'h2
`define NOS_SGF_REL 2'h3
`define NOS_FLAG_BIT 31

// ****************************************
// reset values
// ****************************************
`define NOS_THR_RST 32'h000007D0
`define NOS_DT_RST 32'h00000008
`define NOS_K_RST 32'h00000005
`define NOS_REL_RST 32'h8000000C
`define NOS_UN_RST 24'h002710

`endif

/* File: src/nos_pkg.sv */
// types shared by the neutral overvoltage stage
package nos_pkg;
	typedef enum logic [2:0] {
		NOS_ON = 3'h0,
		NOS_BLOCKED = 3'h1,
		NOS_TEST = 3'h2,
		NOS_TEST_BLK = 3'h3,
		NOS_OFF = 3'h4
	} nos_mode_e;
	typedef enum logic [1:0] {
		NOS_F_NORMAL = 2'h0,
		NOS_F_START = 2'h1,
		NOS_F_TRIP = 2'h2,
		NOS_F_BLOCKED = 2'h3
	} nos_force_e;
	typedef enum logic [1:0] {
		NOS_SEL_NONE = 2'h0,
		NOS_SEL_CALC = 2'h1,
		NOS_SEL_CHAN_A = 2'h2,
		NOS_SEL_CHAN_B = 2'h3
	} nos_insel_e;
	typedef enum logic [1:0] {
		NOS_J_THIRD,
		NOS_J_RATIO,
		NOS_J_IDMT,
		NOS_J_PRIM
	} nos_job_e;
	typedef enum logic [2:0] {
		NOS_S_IDLE,
		NOS_S_FETCH,
		NOS_S_SQRT,
		NOS_S_DIV,
		NOS_S_CMP,
		NOS_S_UPDATE
	} nos_state_e;
endpackage

/* File: src/nos_sg_mem.sv */
// setting group memory: one write port, two registered read ports
`include "nos_defines.svh"
module nos_sg_mem #(
	parameter int NUM_SG = 8
) (
	input wire logic sys_clk, // system clock
	input wire logic rstn, // async reset, active low
	input wire logic we, // write strobe
	input wire logic [$clog2(NUM_SG*4)-1:0] waddr, // write word index
	input wire logic [31:0] wdata, // write data
	input wire logic [$clog2(NUM_SG*4)-1:0] raddr_a, // bus read index
	output logic [31:0] rdata_a, // bus read data
	input wire logic [$clog2(NUM_SG*4)-1:0] raddr_b, // engine read index
	output logic [31:0] rdata_b // engine read data
);
	logic [31:0] mem [NUM_SG*4];

	// ****************************************
	// storage, kept in flops so every group has defaults
	// ****************************************
	for (genvar i = 0; i < NUM_SG * 4; i++) begin : g_word
		// every group starts from the same defaults; a constant keeps the reset branch clean
		localparam logic [31:0] RST_VAL = (i % 4 == 0) ? `NOS_THR_RST : (i % 4 == 1) ?
			`NOS_DT_RST : (i % 4 == 2) ? `NOS_K_RST : `NOS_REL_RST;
		always_ff @(posedge sys_clk or negedge rstn) begin
			if (!rstn) begin
				mem[i] <= RST_VAL;
			end else if (we && waddr == i) begin
				mem[i] <= wdata;
			end
		end
	end

	// registered read ports
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rdata_a <= 32'h0;
			rdata_b <= 32'h0;
		end else begin
			rdata_a <= mem[raddr_a];
			rdata_b <= mem[raddr_b];
		end
	end
endmodule

/* File: src/nos_stage.sv */
// neutral overvoltage stage: apb registers, program-cycle engine, pick-up and timing
// ****************************************
// Functional notes
// - calc source: residual is one third of the summed three phase phasors
// - only fundamental-frequency magnitudes feed the comparison
// - residual scaled so a full earth fault reads 100 percent nominal
// - static input select: unset, calculated, channel a or channel b
// - channel a or b selectable only when configured as residual channel
// - mode On, Blocked, Test, Test/Blocked or Off; On after reset
// - forcing to Normal, Start, Trip or Blocked when forcing enabled
// - mode, forcing and input select are static, not in setting groups
// - pick-up when magnitude exceeds threshold, same threshold for every source
// - release only below 97 percent of the threshold setting
// - threshold in 0.01 percent steps, default 20.00 percent
// - setting group switch changes parameters while running
// - unset select falls back to calc, else no residual flagged
// - expected operating time in 5 ms steps, tracks voltage in inverse mode
// - signed time remaining to trip in 5 ms steps
// - measured to setting ratio in 0.01 steps
// - threshold as primary voltage in 0.1 V steps
// - block sampled per program cycle; blocked instead of start
// ****************************************
//
// The implementer's own choices: the register offsets and the APB slave port.
`include "nos_defines.svh"
module nos_stage #(
	parameter int NUM_SG = 8,
	parameter int PROG_CYCLE_CLKS = `NOS_PROG_CYCLE_CLKS
) (
	input wire logic sys_clk, // system clock, 100 MHz
	input wire logic rstn, // async reset, active low
	input wire logic [11:0] paddr, // apb address
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [31:0] pwdata, // apb write data
	output logic pready, // apb ready
	output logic [31:0] prdata, // apb read data
	output logic pslverr, // apb error on unmapped address
	input wire logic signed [15:0] ul1_re, // phase 1 fundamental, real part
	input wire logic signed [15:0] ul1_im, // phase 1 fundamental, imaginary part
	input wire logic signed [15:0] ul2_re, // phase 2 fundamental, real part
	input wire logic signed [15:0] ul2_im, // phase 2 fundamental, imaginary part
	input wire logic signed [15:0] ul3_re, // phase 3 fundamental, real part
	input wire logic signed [15:0] ul3_im, // phase 3 fundamental, imaginary part
	input wire logic ln_present, // phase-to-neutral voltages connected
	input wire logic [15:0] residual_channel_a, // channel a fundamental magnitude
	input wire logic [15:0] residual_channel_b, // channel b fundamental magnitude
	input wire logic chan_a_res_mode, // channel a configured as residual input
	input wire logic chan_b_res_mode, // channel b configured as residual input
	input wire logic block_in, // blocking input
	input wire logic sg_logic_req, // user logic group change pulse
	input wire logic [2:0] sg_logic_sel, // user logic group index
	output logic start_o, // start indication
	output logic trip_o, // trip indication
	output logic blocked_o, // blocked indication
	output logic test_o, // stage runs in a test mode
	output logic no_residual_flag, // no residual voltage available
	output logic [1:0] meas_now_o // channel in use
);
	localparam int AW = $clog2(NUM_SG * 4);
	localparam int SW = $clog2(NUM_SG);
	localparam int TW = $clog2(PROG_CYCLE_CLKS);

	// ****************************************
	// declarations
	// ****************************************
	nos_pkg::nos_mode_e ctrl_mode;
	nos_pkg::nos_force_e ctrl_force;
	nos_pkg::nos_insel_e ctrl_insel;
	logic ctrl_fen;
	logic [SW-1:0] active_sg;
	logic [23:0] un_prim [3];
	logic [TW-1:0] tick_cnt;
	logic tick;
	logic acc, wr_en;
	logic [11:0] sg_off;
	logic sg_hit, reg_hit;
	logic [31:0] mem_rdata_a, mem_rdata_b;
	logic [AW-1:0] eng_raddr;
	nos_pkg::nos_state_e state;
	nos_pkg::nos_job_e job;
	nos_pkg::nos_insel_e meas_now;
	logic [2:0] fcnt;
	logic [SW-1:0] eng_sg;
	logic blk_s;
	logic [15:0] thr, mag;
	logic [31:0] dt_word, k_word, rel_word;
	logic signed [17:0] s_re, s_im;
	logic [35:0] rad;
	logic [17:0] root;
	logic [4:0] sbit;
	logic [17:0] trial;
	logic [39:0] dnum;
	logic [31:0] dden;
	logic [32:0] rem;
	logic [32:0] rem_sh;
	logic [5:0] dcnt;
	logic pickup;
	logic [31:0] ratio, exp_t, prim;
	logic [31:0] elapsed, rel_cnt;
	logic st_start, st_trip, st_blocked;
	logic signed [31:0] remain;

	// program-cycle tick: one pulse per time step
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			tick_cnt <= '0;
			tick <= 1'b0;
		end else begin
			tick <= (tick_cnt == TW'(PROG_CYCLE_CLKS - 1));
			tick_cnt <= (tick_cnt == TW'(PROG_CYCLE_CLKS - 1)) ? '0 : tick_cnt + 1'b1;
		end
	end

	// ****************************************
	// apb slave
	// ****************************************
	assign acc = psel & penable;
	assign wr_en = acc & pready & pwrite;
	assign sg_off = paddr - `NOS_SG_BASE;
	assign sg_hit = (paddr >= `NOS_SG_BASE) && (sg_off < 12'(NUM_SG * 16));
	assign reg_hit = (paddr[1:0] == 2'h0) && (paddr <= `NOS_UN_B);

	// every access takes two access cycles; pready comes from a flop
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready <= acc & ~pready;
			pslverr <= acc & ~pready & ~(reg_hit | sg_hit);
			prdata <= 32'h0;
			if (acc && !pready && !pwrite) begin
				if (sg_hit) begin
					prdata <= mem_rdata_a;
				end else begin
					case (paddr)
						`NOS_CTRL: prdata <= {19'h0, ctrl_fen, 2'h0, ctrl_insel, 2'h0,
							ctrl_force, 1'b0, ctrl_mode};
						`NOS_STAT: prdata <= {19'h0, no_residual_flag, 1'b0, ctrl_mode,
							st_blocked, st_trip, st_start, pickup, 2'h0, meas_now};
						`NOS_EXPT: prdata <= exp_t;
						`NOS_REMT: prdata <= remain;
						`NOS_RATIO: prdata <= ratio;
						`NOS_PRIM: prdata <= prim;
						`NOS_SGSEL: prdata <= 32'(active_sg);
						`NOS_UN_CALC: prdata <= {8'h0, un_prim[0]};
						`NOS_UN_A: prdata <= {8'h0, un_prim[1]};
						`NOS_UN_B: prdata <= {8'h0, un_prim[2]};
						default: prdata <= 32'h0;
					endcase
				end
			end
		end
	end

	// static general settings; group switching never reaches them
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_mode <= nos_pkg::NOS_ON;
			ctrl_force <= nos_pkg::NOS_F_NORMAL;
			ctrl_insel <= nos_pkg::NOS_SEL_NONE;
			ctrl_fen <= 1'b0;
		end else if (wr_en && paddr == `NOS_CTRL) begin
			// an undefined mode code is ignored so the stage never sits in limbo
			if (pwdata[`NOS_CTRL_MODE+:3] <= 3'(nos_pkg::NOS_OFF)) begin
				ctrl_mode <= nos_pkg::nos_mode_e'(pwdata[`NOS_CTRL_MODE+:3]);
			end
			ctrl_force <= nos_pkg::nos_force_e'(pwdata[`NOS_CTRL_FORCE+:2]);
			ctrl_fen <= pwdata[`NOS_CTRL_FEN];
			// residual channels only offered once configured for it
			case (nos_pkg::nos_insel_e'(pwdata[`NOS_CTRL_INSEL+:2]))
				nos_pkg::NOS_SEL_CHAN_A: if (chan_a_res_mode) ctrl_insel <= nos_pkg::NOS_SEL_CHAN_A;
				nos_pkg::NOS_SEL_CHAN_B: if (chan_b_res_mode) ctrl_insel <= nos_pkg::NOS_SEL_CHAN_B;
				default: ctrl_insel <= nos_pkg::nos_insel_e'(pwdata[`NOS_CTRL_INSEL+:2]);
			endcase
		end
	end

	// active group: user logic wins over a software write in the same cycle
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			active_sg <= '0;
		end else if (sg_logic_req && 32'(sg_logic_sel) < NUM_SG) begin
			active_sg <= SW'(sg_logic_sel);
		end else if (wr_en && paddr == `NOS_SGSEL && pwdata < NUM_SG) begin
			active_sg <= SW'(pwdata);
		end
	end

	// transformer primary nominal voltages per source, in volts
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			un_prim[0] <= `NOS_UN_RST;
			un_prim[1] <= `NOS_UN_RST;
			un_prim[2] <= `NOS_UN_RST;
		end else if (wr_en) begin
			if (paddr == `NOS_UN_CALC) un_prim[0] <= pwdata[23:0];
			if (paddr == `NOS_UN_A) un_prim[1] <= pwdata[23:0];
			if (paddr == `NOS_UN_B) un_prim[2] <= pwdata[23:0];
		end
	end

	// ****************************************
	// setting group memory
	// ****************************************
	assign eng_raddr = AW'({eng_sg, fcnt[1:0]});

	nos_sg_mem #(
		.NUM_SG(NUM_SG)
	) nos_sg_mem_i (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.we(wr_en & sg_hit),
		.waddr(sg_off[AW+1:2]),
		.wdata(pwdata),
		.raddr_a(sg_off[AW+1:2]),
		.rdata_a(mem_rdata_a),
		.raddr_b(eng_raddr),
		.rdata_b(mem_rdata_b)
	);

	// ****************************************
	// program-cycle engine
	// ****************************************
	assign trial = root | (18'h1 << sbit);
	assign rem_sh = {rem[31:0], dnum[39]};

	// fetch settings, form the magnitude, compare, then run the divisions
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state <= nos_pkg::NOS_S_IDLE;
			job <= nos_pkg::NOS_J_THIRD;
			meas_now <= nos_pkg::NOS_SEL_NONE;
			fcnt <= 3'h0;
			eng_sg <= '0;
			blk_s <= 1'b0;
			thr <= 16'(`NOS_THR_RST);
			dt_word <= `NOS_DT_RST;
			k_word <= `NOS_K_RST;
			rel_word <= `NOS_REL_RST;
			s_re <= 18'sh0;
			s_im <= 18'sh0;
			rad <= 36'h0;
			root <= 18'h0;
			sbit <= 5'h0;
			mag <= 16'h0;
			dnum <= 40'h0;
			dden <= 32'h1;
			rem <= 33'h0;
			dcnt <= 6'h0;
			pickup <= 1'b0;
			ratio <= 32'h0;
			exp_t <= `NOS_DT_RST;
			prim <= 32'h0;
		end else begin
			case (state)
				nos_pkg::NOS_S_IDLE: if (tick) begin
					blk_s <= block_in; // sampled once per program cycle
					eng_sg <= active_sg; // new group takes effect next cycle
					fcnt <= 3'h0;
					// unset select falls back to calc only with phase voltages
					case (ctrl_insel)
						nos_pkg::NOS_SEL_NONE, nos_pkg::NOS_SEL_CALC:
							meas_now <= ln_present ? nos_pkg::NOS_SEL_CALC : nos_pkg::NOS_SEL_NONE;
						default: meas_now <= ctrl_insel;
					endcase
					// phasor sum of the three fundamentals
					s_re <= 18'(ul1_re) + 18'(ul2_re) + 18'(ul3_re);
					s_im <= 18'(ul1_im) + 18'(ul2_im) + 18'(ul3_im);
					state <= nos_pkg::NOS_S_FETCH;
				end
				nos_pkg::NOS_S_FETCH: begin
					fcnt <= fcnt + 3'h1;
					case (fcnt)
						3'h1: thr <= mem_rdata_b[15:0];
						3'h2: dt_word <= mem_rdata_b;
						3'h3: k_word <= mem_rdata_b;
						3'h4: rel_word <= mem_rdata_b;
						default: ;
					endcase
					if (fcnt == 3'h4) begin
						rad <= 36'(s_re * s_re) + 36'(s_im * s_im);
						root <= 18'h0;
						sbit <= 5'(`NOS_SQRT_BITS - 1);
						// dedicated channels are already fundamental magnitudes
						case (meas_now)
							nos_pkg::NOS_SEL_CALC: state <= nos_pkg::NOS_S_SQRT;
							nos_pkg::NOS_SEL_CHAN_A: begin
								mag <= residual_channel_a;
								state <= nos_pkg::NOS_S_CMP;
							end
							nos_pkg::NOS_SEL_CHAN_B: begin
								mag <= residual_channel_b;
								state <= nos_pkg::NOS_S_CMP;
							end
							default: begin
								mag <= 16'h0;
								state <= nos_pkg::NOS_S_CMP;
							end
						endcase
					end
				end
				nos_pkg::NOS_S_SQRT: begin
					// bitwise square root, msb first
					if (36'(trial * trial) <= rad) root <= trial;
					if (sbit == 5'h0) begin
						state <= nos_pkg::NOS_S_DIV;
						job <= nos_pkg::NOS_J_THIRD;
						dcnt <= 6'(`NOS_DIV_STEPS);
						rem <= 33'h0;
						dnum <= 40'(trial * trial <= rad ? trial : root);
						dden <= 32'h3; // one third of the sum, phase scale gives 100 %
					end
					sbit <= sbit - 5'h1;
				end
				nos_pkg::NOS_S_CMP: begin
					// pick-up above threshold, release under 97 % of it
					if (!pickup) begin
						pickup <= (meas_now != nos_pkg::NOS_SEL_NONE) && (mag > thr);
					end else begin
						pickup <= !(24'(mag) * 24'(`NOS_PCT_FULL) < 24'(thr) * 24'(`NOS_HYST_PCT));
					end
					state <= nos_pkg::NOS_S_DIV;
					job <= nos_pkg::NOS_J_RATIO;
					dcnt <= 6'(`NOS_DIV_STEPS);
					rem <= 33'h0;
					dnum <= 40'(mag) * 40'(`NOS_PCT_FULL);
					dden <= (thr == 16'h0) ? 32'h1 : 32'(thr);
				end
				nos_pkg::NOS_S_DIV: begin
					if (dcnt != 6'h0) begin
						// restoring division, quotient shifts into dnum
						dcnt <= dcnt - 6'h1;
						if (rem_sh >= 33'(dden)) begin
							rem <= rem_sh - 33'(dden);
							dnum <= {dnum[38:0], 1'b1};
						end else begin
							rem <= rem_sh;
							dnum <= {dnum[38:0], 1'b0};
						end
					end else begin
						dcnt <= 6'(`NOS_DIV_STEPS);
						rem <= 33'h0;
						case (job)
							nos_pkg::NOS_J_THIRD: begin
								mag <= (dnum > 40'hFFFF) ? 16'hFFFF : dnum[15:0];
								state <= nos_pkg::NOS_S_CMP;
							end
							nos_pkg::NOS_J_RATIO: begin
								ratio <= (dnum > 40'(`NOS_RATIO_MAX)) ? 32'(`NOS_RATIO_MAX) : dnum[31:0];
								// inverse time uses the live ratio, exponent one
								if (dt_word[`NOS_FLAG_BIT] && dnum > 40'(`NOS_PCT_FULL)) begin
									job <= nos_pkg::NOS_J_IDMT;
									dnum <= 40'(k_word[15:0]) * 40'(`NOS_IDMT_SCALE);
									dden <= dnum[31:0] - 32'(`NOS_PCT_FULL);
								end else begin
									exp_t <= dt_word[`NOS_FLAG_BIT] ? 32'(`NOS_TIME_MAX) : {13'h0, dt_word[18:0]};
									job <= nos_pkg::NOS_J_PRIM;
									dnum <= 40'(thr) * 40'(un_prim[meas_now == nos_pkg::NOS_SEL_NONE ? 0 : 32'(meas_now) - 1]);
									dden <= 32'(`NOS_PRIM_DIV);
								end
							end
							nos_pkg::NOS_J_IDMT: begin
								exp_t <= (dnum > 40'(`NOS_TIME_MAX)) ? 32'(`NOS_TIME_MAX) : dnum[31:0];
								job <= nos_pkg::NOS_J_PRIM;
								dnum <= 40'(thr) * 40'(un_prim[meas_now == nos_pkg::NOS_SEL_NONE ? 0 : 32'(meas_now) - 1]);
								dden <= 32'(`NOS_PRIM_DIV);
							end
							default: begin
								prim <= dnum[31:0]; // primary threshold in 0.1 V
								state <= nos_pkg::NOS_S_UPDATE;
							end
						endcase
					end
				end
				nos_pkg::NOS_S_UPDATE: state <= nos_pkg::NOS_S_IDLE;
				default: state <= nos_pkg::NOS_S_IDLE;
			endcase
		end
	end

	// ****************************************
	// start, trip and release timing
	// ****************************************
	// blocked mode acts like a held block input for start, trip and blocked; off clears those and the timers, not remain
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_start <= 1'b0;
			st_trip <= 1'b0;
			st_blocked <= 1'b0;
			elapsed <= 32'h0;
			rel_cnt <= 32'h0;
			remain <= 32'sh0;
		end else if (state == nos_pkg::NOS_S_UPDATE) begin
			if (ctrl_mode == nos_pkg::NOS_OFF) begin
				st_start <= 1'b0;
				st_trip <= 1'b0;
				st_blocked <= 1'b0;
				elapsed <= 32'h0;
				rel_cnt <= 32'h0;
			end else if (pickup && (blk_s || ctrl_mode == nos_pkg::NOS_BLOCKED)) begin
				// blocked instead of start, no further processing
				st_start <= 1'b0;
				st_trip <= 1'b0;
				st_blocked <= 1'b1;
				elapsed <= 32'h0;
				rel_cnt <= 32'h0;
			end else if (pickup) begin
				st_start <= 1'b1;
				st_blocked <= 1'b0;
				rel_cnt <= 32'h0;
				// a zero delay trips together with the start
				st_trip <= (elapsed + 32'h1 >= exp_t) || exp_t == 32'h0;
				if (elapsed < 32'(`NOS_TIME_MAX)) elapsed <= elapsed + 32'h1;
			end else begin
				st_trip <= 1'b0;
				st_blocked <= 1'b0;
				// delayed release holds start and the timer for the release time
				if (st_start && rel_word[`NOS_FLAG_BIT] && rel_cnt + 32'h1 < 32'(rel_word[15:0])) begin
					rel_cnt <= rel_cnt + 32'h1;
				end else begin
					st_start <= 1'b0;
					elapsed <= 32'h0;
					rel_cnt <= 32'h0;
				end
			end
			// remaining time while counting toward a trip
			remain <= (pickup && !blk_s) ? $signed(exp_t - elapsed) - 32'sh1 : 32'sh0;
		end
	end

	// ****************************************
	// outputs, forcing and test suppression
	// ****************************************
	// test/blocked runs the stage but keeps start, trip and blocked quiet unless forcing is active
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			start_o <= 1'b0;
			trip_o <= 1'b0;
			blocked_o <= 1'b0;
			test_o <= 1'b0;
			no_residual_flag <= 1'b0;
			meas_now_o <= 2'h0;
		end else begin
			test_o <= ctrl_mode == nos_pkg::NOS_TEST || ctrl_mode == nos_pkg::NOS_TEST_BLK;
			no_residual_flag <= meas_now == nos_pkg::NOS_SEL_NONE;
			meas_now_o <= meas_now;
			if (ctrl_fen && ctrl_force != nos_pkg::NOS_F_NORMAL) begin
				start_o <= ctrl_force == nos_pkg::NOS_F_START || ctrl_force == nos_pkg::NOS_F_TRIP;
				trip_o <= ctrl_force == nos_pkg::NOS_F_TRIP;
				blocked_o <= ctrl_force == nos_pkg::NOS_F_BLOCKED;
			end else if (ctrl_mode == nos_pkg::NOS_TEST_BLK) begin
				start_o <= 1'b0;
				trip_o <= 1'b0;
				blocked_o <= 1'b0;
			end else begin
				start_o <= st_start;
				trip_o <= st_trip;
				blocked_o <= st_blocked;
			end
		end
	end
endmodule
